/* File: shared/asrc_map.svh */
// timing, width and encoding constants for the async sram host controller
`ifndef ASRC_MAP_SVH
`define ASRC_MAP_SVH
`define ASRC_CLK_PS 5000
`define ASRC_ADDR_W 10
`define ASRC_DATA_W 4
// speed grade selects: 0 fastest, 1 middle, 2 slowest
`define ASRC_GRADE_FAST 2'h0
`define ASRC_GRADE_MID 2'h1
`define ASRC_GRADE_SLOW 2'h2
// read access / read cycle, ns per grade
`define ASRC_ACCESS_NS_G0 25
`define ASRC_ACCESS_NS_G1 35
`define ASRC_ACCESS_NS_G2 45
// write cycle and select-to-end, ns per grade
`define ASRC_WCYC_NS_G0 20
`define ASRC_WCYC_NS_G1 30
`define ASRC_WCYC_NS_G2 40
// write strobe width and data setup, ns per grade
`define ASRC_WPULSE_NS_G0 15
`define ASRC_WPULSE_NS_G1 20
`define ASRC_WPULSE_NS_G2 25
// write-to-float (device drive release) worst case, ns per grade
`define ASRC_WFLOAT_NS_G0 15
`define ASRC_WFLOAT_NS_G1 20
`define ASRC_WFLOAT_NS_G2 20
// deselect-to-float worst case, ns per grade
`define ASRC_DFLOAT_NS_G0 15
`define ASRC_DFLOAT_NS_G1 20
`define ASRC_DFLOAT_NS_G2 20
// deselect to standby current, ns
`define ASRC_STBY_NS 30
// least cycles from time in ns, rounded up, at least one
`define ASRC_CYC(ns) ((((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS) \
    < 1 ? 1 : (((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS))
`define ASRC_CNT_W 4
`endif

/* File: shared/asrc_pkg.sv */
// types for the async sram host controller
package asrc_pkg;
    typedef enum logic [2:0] {
        ASRC_IDLE,
        ASRC_READ,
        ASRC_WR_SETUP,
        ASRC_WR_STROBE,
        ASRC_WR_RECOV,
        ASRC_DESEL
    } asrc_state_t;
endpackage

/* File: verilog/asrc_sync.sv */
// two flip-flop synchroniser for the shared data lines
`timescale 1ns/1ps
`include "asrc_map.svh"
module asrc_sync #(
    parameter int WIDTH = `ASRC_DATA_W
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ---------------------------------------------------------------
    // per-bit double flop
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= d_i[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign q_o = sync_ff;
endmodule

/* File: verilog/asrc_host.sv */
// host-side controller driving a 1k x 4 asynchronous static ram
// ---------------------------------------------------------------
// Notes on behaviour
// - write strobe stays high through every read cycle
// - write cycle 20/30/40 ns, strobe low 15/20/25 ns
// - select low at least 20/30/40 ns before strobe rises
// - write data valid 15/20/25 ns before strobe rises, zero hold
// - address stable by strobe fall, 20/30/40 ns before rise
// - address changes only while select or strobe is high
// - write spans later falling to first rising of select/strobe
// - host drives data only after write-to-float time passes
// ---------------------------------------------------------------
`timescale 1ns/1ps
`include "asrc_map.svh"
module asrc_host #(
    parameter logic [1:0] GRADE = `ASRC_GRADE_FAST,
    parameter int AW = `ASRC_ADDR_W,
    parameter int DW = `ASRC_DATA_W
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic [DW-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic rd_valid_o,
    output logic [DW-1:0] rd_data_o,
    output logic [AW-1:0] word_select_lines_o,
    output logic chip_select_n_o,
    output logic write_strobe_n_o,
    input wire logic [DW-1:0] data_lines_i,
    output logic [DW-1:0] data_lines_o,
    output logic [DW-1:0] data_lines_oe_o
);
    // ---------------------------------------------------------------
    // timing counts per grade
    // ---------------------------------------------------------------
    localparam int ACC_NS = (GRADE == `ASRC_GRADE_FAST) ?
        `ASRC_ACCESS_NS_G0 : (GRADE == `ASRC_GRADE_MID) ?
        `ASRC_ACCESS_NS_G1 : `ASRC_ACCESS_NS_G2;
    localparam int WCYC_NS = (GRADE == `ASRC_GRADE_FAST) ?
        `ASRC_WCYC_NS_G0 : (GRADE == `ASRC_GRADE_MID) ?
        `ASRC_WCYC_NS_G1 : `ASRC_WCYC_NS_G2;
    localparam int WPUL_NS = (GRADE == `ASRC_GRADE_FAST) ?
        `ASRC_WPULSE_NS_G0 : (GRADE == `ASRC_GRADE_MID) ?
        `ASRC_WPULSE_NS_G1 : `ASRC_WPULSE_NS_G2;
    localparam int WFLT_NS = (GRADE == `ASRC_GRADE_FAST) ?
        `ASRC_WFLOAT_NS_G0 : (GRADE == `ASRC_GRADE_MID) ?
        `ASRC_WFLOAT_NS_G1 : `ASRC_WFLOAT_NS_G2;
    localparam int DFLT_NS = (GRADE == `ASRC_GRADE_FAST) ?
        `ASRC_DFLOAT_NS_G0 : (GRADE == `ASRC_GRADE_MID) ?
        `ASRC_DFLOAT_NS_G1 : `ASRC_DFLOAT_NS_G2;
    // read waits access, one margin cycle, then two sync stages;
    // sampling right at the access time would race the data
    localparam int RD_CYC = `ASRC_CYC(ACC_NS) + 3;
    // strobe low long enough for width, data setup, address setup
    localparam int WL_CYC = `ASRC_CYC(WCYC_NS);
    // host drive held off until the device has surely floated
    localparam int WF_CYC = `ASRC_CYC(WFLT_NS);
    localparam int DS_CYC = `ASRC_CYC(DFLT_NS) > `ASRC_CYC(`ASRC_STBY_NS) ?
        `ASRC_CYC(DFLT_NS) : `ASRC_CYC(`ASRC_STBY_NS);
    localparam logic [`ASRC_CNT_W-1:0] RD_N = `ASRC_CNT_W'(RD_CYC - 1);
    localparam logic [`ASRC_CNT_W-1:0] WL_N = `ASRC_CNT_W'(WL_CYC - 1);
    localparam logic [`ASRC_CNT_W-1:0] WF_N = `ASRC_CNT_W'(WF_CYC - 1);
    localparam logic [`ASRC_CNT_W-1:0] DS_N = `ASRC_CNT_W'(DS_CYC - 1);
    localparam logic [`ASRC_CNT_W-1:0] CNT_ZERO = `ASRC_CNT_W'(0);

    asrc_pkg::asrc_state_t state_ff, nxt_state;
    logic [`ASRC_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [DW-1:0] wdata_ff, nxt_wdata;
    logic [DW-1:0] rdata_ff, nxt_rdata;
    logic cs_n_ff, nxt_cs_n;
    logic we_n_ff, nxt_we_n;
    logic oe_ff, nxt_oe;
    logic ready_ff, nxt_ready;
    logic rvalid_ff, nxt_rvalid;
    logic [DW-1:0] data_sync;

    // pins are asynchronous to mclk_i
    asrc_sync #(
        .WIDTH(DW)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(data_lines_i),
        .q_o(data_sync)
    );

    wire cnt_done = (cnt_ff == CNT_ZERO);
    wire cnt_dec_en = !cnt_done;
    wire [`ASRC_CNT_W-1:0] cnt_dec = cnt_ff - `ASRC_CNT_W'(1);
    wire take_req = ready_ff && req_i;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_dec_en ? cnt_dec : cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_cs_n = cs_n_ff;
        nxt_we_n = we_n_ff;
        nxt_oe = oe_ff;
        nxt_ready = 1'b0;
        nxt_rvalid = 1'b0;
        unique case (state_ff)
            asrc_pkg::ASRC_IDLE: begin
                nxt_ready = !take_req;
                if (take_req) begin
                    nxt_addr = req_addr_i;
                    nxt_wdata = req_wdata_i;
                    // select falls first; strobe later starts write
                    nxt_cs_n = 1'b0;
                    if (req_write_i) begin
                        // wait out device float before driving
                        nxt_state = asrc_pkg::ASRC_WR_SETUP;
                        nxt_cnt = CNT_ZERO;
                    end else begin
                        // strobe high for the whole read
                        nxt_we_n = 1'b1;
                        nxt_state = asrc_pkg::ASRC_READ;
                        nxt_cnt = RD_N;
                    end
                end
            end
            asrc_pkg::ASRC_READ: begin
                // sample only after access time plus sync
                if (cnt_done) begin
                    nxt_rdata = data_sync;
                    nxt_rvalid = 1'b1;
                    nxt_cs_n = 1'b1;
                    nxt_state = asrc_pkg::ASRC_DESEL;
                    nxt_cnt = DS_N;
                end
            end
            asrc_pkg::ASRC_WR_SETUP: begin
                // address already stable as strobe falls
                nxt_we_n = 1'b0;
                nxt_state = asrc_pkg::ASRC_WR_STROBE;
                nxt_cnt = WF_N;
            end
            asrc_pkg::ASRC_WR_STROBE: begin
                // drive data once device has floated
                if (cnt_done && !oe_ff) begin
                    nxt_oe = 1'b1;
                    nxt_cnt = WL_N;
                end else if (cnt_done && oe_ff) begin
                    nxt_we_n = 1'b1;
                    nxt_state = asrc_pkg::ASRC_WR_RECOV;
                end
            end
            asrc_pkg::ASRC_WR_RECOV: begin
                // zero hold; release the lines right after
                nxt_oe = 1'b0;
                nxt_cs_n = 1'b1;
                nxt_state = asrc_pkg::ASRC_DESEL;
                nxt_cnt = DS_N;
            end
            asrc_pkg::ASRC_DESEL: begin
                // let device float before next cycle
                if (cnt_done) begin
                    nxt_state = asrc_pkg::ASRC_IDLE;
                    nxt_ready = 1'b1;
                end
            end
        endcase
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff <= asrc_pkg::ASRC_IDLE;
            cnt_ff <= CNT_ZERO;
            addr_ff <= '0;
            wdata_ff <= '0;
            rdata_ff <= '0;
            cs_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            ready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            cs_n_ff <= nxt_cs_n;
            we_n_ff <= nxt_we_n;
            oe_ff <= nxt_oe;
            ready_ff <= nxt_ready;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign word_select_lines_o = addr_ff;
    assign chip_select_n_o = cs_n_ff;
    assign write_strobe_n_o = we_n_ff;
    assign data_lines_o = wdata_ff;
    assign data_lines_oe_o = {DW{oe_ff}};
    assign req_ready_o = ready_ff;
    assign rd_valid_o = rvalid_ff;
    assign rd_data_o = rdata_ff;
endmodule

/* File: test/asrc_host_asserts.sv */
// pin-order checks for the sram host controller
`timescale 1ns/1ps
module asrc_host_asserts #(
    parameter int AW = 10,
    parameter int DW = 4
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_ready_o,
    input wire logic [AW-1:0] word_select_lines_o,
    input wire logic chip_select_n_o,
    input wire logic write_strobe_n_o,
    input wire logic [DW-1:0] data_lines_o,
    input wire logic [DW-1:0] data_lines_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire rd_take = req_i && req_ready_o && !req_write_i;
    // -------------------------------------------
    // host obligations on the pins
    // -------------------------------------------
    a_read_strobe_high: assert property (
        rd_take |=> (write_strobe_n_o && data_lines_oe_o == '0) [*8])
        else $error("strobe or drive during a read");
    a_strobe_width: assert property (
        $fell(write_strobe_n_o) |-> !write_strobe_n_o [*3])
        else $error("write strobe too short");
    a_select_lead: assert property (
        $rose(write_strobe_n_o) |-> !$past(chip_select_n_o, 4))
        else $error("select not early enough");
    a_data_setup: assert property (
        $rose(write_strobe_n_o) |-> $past(data_lines_oe_o, 3) == '1
            && $past(data_lines_o, 3) == data_lines_o)
        else $error("write data setup short");
    a_addr_setup: assert property (
        $rose(write_strobe_n_o)
            |-> $past(word_select_lines_o, 4) == word_select_lines_o)
        else $error("address setup short");
    a_addr_hold: assert property (
        !chip_select_n_o && !write_strobe_n_o
            |-> $stable(word_select_lines_o))
        else $error("address moved in a write");
    a_float_wait: assert property (
        $fell(write_strobe_n_o) |-> (data_lines_oe_o == '0) [*3])
        else $error("host drove before device float");
    a_drive_selected: assert property (
        data_lines_oe_o != '0 |-> !chip_select_n_o)
        else $error("host drove while deselected");
    a_write_frame: assert property (
        $fell(write_strobe_n_o) |-> !$past(chip_select_n_o)
            ##7 (write_strobe_n_o && !chip_select_n_o))
        else $error("write frame order wrong");
endmodule
bind asrc_host asrc_host_asserts #(.AW(AW), .DW(DW)) u_chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_ready_o(req_ready_o),
    .word_select_lines_o(word_select_lines_o),
    .chip_select_n_o(chip_select_n_o),
    .write_strobe_n_o(write_strobe_n_o), .data_lines_o(data_lines_o),
    .data_lines_oe_o(data_lines_oe_o));

/* File: test/asrc_sram_model.sv */
// behavioural 1k x 4 static ram on the far side
`timescale 1ns/1ps
`include "asrc_map.svh"
module asrc_sram_model #(
    parameter int ACC_NS = `ASRC_ACCESS_NS_G0
) (
    input wire logic [9:0] addr_i,
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic [3:0] host_d_i,
    input wire logic [3:0] host_oe_i,
    output logic [3:0] pin_o,
    output logic clash_o
);
    logic [3:0] mem [0:1023];
    logic [3:0] q = 4'h0;
    logic drv = 1'b0;
    wire rd = !cs_n_i && we_n_i;
    // write lands at first rise of select or strobe
    always @(posedge we_n_i or posedge cs_n_i) begin
        if (!cs_n_i || !we_n_i)
            mem[addr_i] <= pin_o;
    end
    always @(rd) begin
        drv <= #(rd ? 5 : 15) rd;
    end
    // junk after 5 ns, data at access time
    always @(addr_i or rd) begin
        q <= #5 ~mem[addr_i];
        q <= #(ACC_NS) mem[addr_i];
    end
    // floating lines show the inverse, never old data
    assign pin_o = (host_oe_i & host_d_i) | (~host_oe_i & (drv ? q : ~q));
    assign clash_o = drv && (|host_oe_i);
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the sram host controller
`timescale 1ns/1ps
`include "asrc_map.svh"
module tb_top;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic req_i = 1'b0;
    logic req_write_i = 1'b0;
    logic [9:0] req_addr_i = 10'h000;
    logic [3:0] req_wdata_i = 4'h0;
    logic req_ready_o, rd_valid_o, chip_select_n_o, write_strobe_n_o;
    logic [3:0] rd_data_o, data_lines_i, data_lines_o, data_lines_oe_o;
    logic [9:0] word_select_lines_o;
    logic clash, clash_seen = 1'b0;
    int errors = 0;
    int n_tests = 0;
    wire [3:0] pins = {chip_select_n_o, write_strobe_n_o, req_ready_o,
        rd_valid_o};
    // write flag, address, write data or expected read data
    logic [14:0] rows [0:10] = '{
        {1'b1, 10'h000, 4'h5}, {1'b1, 10'h3ff, 4'ha}, {1'b1, 10'h155, 4'hf},
        {1'b1, 10'h2aa, 4'h0}, {1'b0, 10'h000, 4'h5}, {1'b0, 10'h3ff, 4'ha},
        {1'b0, 10'h155, 4'hf}, {1'b0, 10'h2aa, 4'h0}, {1'b1, 10'h000, 4'h3},
        {1'b0, 10'h000, 4'h3}, {1'b0, 10'h3ff, 4'ha}};
    asrc_host #(.GRADE(`ASRC_GRADE_FAST)) dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req_i),
        .req_write_i(req_write_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .word_select_lines_o(word_select_lines_o),
        .chip_select_n_o(chip_select_n_o),
        .write_strobe_n_o(write_strobe_n_o), .data_lines_i(data_lines_i),
        .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o));
    asrc_sram_model u_ram (
        .addr_i(word_select_lines_o), .cs_n_i(chip_select_n_o),
        .we_n_i(write_strobe_n_o), .host_d_i(data_lines_o),
        .host_oe_i(data_lines_oe_o), .pin_o(data_lines_i), .clash_o(clash));
    always #2.5 mclk_i = ~mclk_i;
    // mid-cycle sampling keeps the overlap test clear of edge races
    always @(negedge mclk_i) begin
        if (clash === 1'b1)
            clash_seen <= 1'b1;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic xfer(input logic [14:0] r);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        check({3'h0, req_ready_o}, 4'h1);
        req_i <= 1'b1;
        {req_write_i, req_addr_i, req_wdata_i} <= r;
        @(posedge mclk_i);
        req_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic read_exp(input logic [9:0] a, input logic [3:0] want);
        int n;
        xfer({1'b0, a, 4'h0});
        n = 0;
        while (rd_valid_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        check({3'h0, rd_valid_o}, 4'h1);
        check(rd_data_o, want);
        @(posedge mclk_i);
        check({3'h0, rd_valid_o}, 4'h0);
    endtask
    // -------------------------------------------
    // test sequence
    // -------------------------------------------
    initial begin
        repeat (20) @(posedge mclk_i);
        check(pins, 4'hc);
        check(data_lines_oe_o, 4'h0);
        $display("reset test done");
        nrst_i <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            if (rows[i][14])
                xfer(rows[i]);
            else
                read_exp(rows[i][13:4], rows[i][3:0]);
        end
        $display("row tests done");
        // request held while busy must be ignored
        xfer({1'b0, 10'h3ff, 4'h0});
        req_i <= 1'b1;
        {req_write_i, req_addr_i, req_wdata_i} <= {1'b1, 10'h2aa, 4'h5};
        repeat (6) @(posedge mclk_i);
        req_i <= 1'b0;
        read_exp(10'h2aa, 4'h0);
        $display("busy refusal test done");
        // abort a read while selected; a write abort would race the ram
        xfer({1'b0, 10'h155, 4'h0});
        nrst_i <= 1'b0;
        @(posedge mclk_i);
        check(pins, 4'hc);
        check(data_lines_oe_o, 4'h0);
        nrst_i <= 1'b1;
        read_exp(10'h155, 4'hf);
        $display("reset abort test done");
        check({3'h0, clash_seen}, 4'h0);
        test_done;
    end
    // about 250 cycles expected; allow several times that
    initial begin
        #(3000 * 5);
        errors++;
        test_done;
    end
endmodule
